//--- otb_pkg.sv
package otb_pkg;

  // Widths
  localparam int OTB_DATA_W = 8;
  localparam int OTB_ADDR_W = 8;
  localparam int OTB_COUNT_W = 16;
  localparam int OTB_BUF_DEPTH = 2;

  // Register byte offsets
  localparam logic [7:0] OTB_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] OTB_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] OTB_A_STORE_OFFSET = 8'h08;
  localparam logic [7:0] OTB_B_STORE_OFFSET = 8'h0C;
  localparam logic [7:0] OTB_COUNT_OFFSET = 8'h10;

  // Status field positions
  localparam int OTB_ST_A_DRIVEN = 0;
  localparam int OTB_ST_B_DRIVEN = 1;
  localparam int OTB_ST_A_CLK = 2;
  localparam int OTB_ST_B_CLK = 3;
  localparam int OTB_ST_OVERFLOW = 4;
  localparam int OTB_ST_CAP_READY = 5;

  // Count field positions
  localparam int OTB_CNT_A_LSB = 0;
  localparam int OTB_CNT_B_LSB = 16;

  // Bus answers
  localparam logic [1:0] OTB_RESP_OKAY = 2'h0;
  localparam logic [1:0] OTB_RESP_SLVERR = 2'h2;

  typedef logic [OTB_DATA_W-1:0] otb_data_t;

  // Output controls, bit 3 downward
  typedef struct packed {
    logic b_to_a_source_select;
    logic a_to_b_source_select;
    logic drive_side_select;
    logic drive_enable_b;
  } otb_ctrl_s;

  // Buses released after reset
  localparam otb_ctrl_s OTB_CTRL_RESET = 4'h1;

  typedef struct packed {
    logic awvalid;
    logic [OTB_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [OTB_ADDR_W-1:0] araddr;
    logic rready;
  } otb_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } otb_axi_rsp_s;

  // One capture event
  typedef struct packed {
    logic a_hit;
    logic b_hit;
    otb_data_t a_data;
    otb_data_t b_data;
  } otb_cap_word_s;

endpackage

//--- otb_pair_buffer.sv
`timescale 1ns/1ps

module otb_pair_buffer #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } otb_buf_state_s;

  otb_buf_state_s cur;
  otb_buf_state_s next_state;

  // Pointer step with wrap at the last entry
  function automatic logic [PW-1:0] otb_bump(input logic [PW-1:0] ptr);
    otb_bump = (ptr == PW'(DEPTH - 1)) ? '0 : ptr + PW'(1);
  endfunction

  logic push;
  logic pop;

  // Full and empty come straight from the count
  assign in_ready_out = (cur.count != CW'(DEPTH));
  assign out_valid_out = (cur.count != '0);
  assign out_data_out = cur.mem[cur.rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Next entry state
  always_comb begin
    next_state = cur;
    if (push) begin
      next_state.mem[cur.wr_ptr] = in_data_in;
      next_state.wr_ptr = otb_bump(cur.wr_ptr);
    end
    if (pop) begin
      next_state.rd_ptr = otb_bump(cur.rd_ptr);
    end
    if (push && !pop) begin
      next_state.count = cur.count + CW'(1);
    end else if (pop && !push) begin
      next_state.count = cur.count - CW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cur <= '0;
    end else begin
      cur <= next_state;
    end
  end

endmodule

//--- otb_top.sv
`timescale 1ns/1ps

// Overview of operation
// - A bus stored on A capture clock rise; B bus on B capture clock rise.
// - Storing happens on every capture edge, whatever the output controls.
// - With drive enabled, side select low drives A, high drives B.
// - Drive disabled: neither bus driven, both stored freely, contents held.
// - Each bus is stored only into its own register, never into the other.
// - Driving A with B-to-A select low: A carries live B.
// - Driving A with B-to-A select high: A carries stored B word.
// - Driving B with A-to-B select low: B carries live A.
// - Driving B with A-to-B select high: B carries stored A word.
// - A capture edge never alters which bus is driven.
// - At most one bus driven; outside logic must not fight it.
module otb_top (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire otb_pkg::otb_axi_req_s axi_req_in,
  output otb_pkg::otb_axi_rsp_s axi_rsp_out,
  input wire logic a_capture_clock_in,
  input wire logic b_capture_clock_in,
  input wire otb_pkg::otb_data_t a_bus_in,
  output otb_pkg::otb_data_t a_bus_out,
  output logic a_bus_oe_out,
  input wire otb_pkg::otb_data_t b_bus_in,
  output otb_pkg::otb_data_t b_bus_out,
  output logic b_bus_oe_out,
  output logic capture_ready_out,
  output logic capture_valid_out,
  input wire logic capture_ready_in,
  output otb_pkg::otb_cap_word_s capture_word_out
);

  // All clocked state except the two storage words
  typedef struct packed {
    otb_pkg::otb_ctrl_s ctrl;
    logic [2:0] a_clk_sync;
    logic [2:0] b_clk_sync;
    logic [2:0][otb_pkg::OTB_DATA_W-1:0] a_sync;
    logic [2:0][otb_pkg::OTB_DATA_W-1:0] b_sync;
    logic primed;
    logic a_clk_level;
    logic b_clk_level;
    logic overflow;
    logic [otb_pkg::OTB_COUNT_W-1:0] a_count;
    logic [otb_pkg::OTB_COUNT_W-1:0] b_count;
    logic a_drive;
    logic b_drive;
    otb_pkg::otb_data_t a_drive_data;
    otb_pkg::otb_data_t b_drive_data;
    logic aw_held;
    logic [otb_pkg::OTB_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } otb_top_state_s;

  otb_top_state_s cur;
  otb_top_state_s next_state;

  // Storage words, deliberately outside the reset domain
  otb_pkg::otb_data_t a_store;
  otb_pkg::otb_data_t b_store;

  // Combinational helpers
  logic a_settled;
  logic b_settled;
  logic a_rise;
  logic b_rise;
  logic cap_push;
  logic buf_ready;
  logic aw_ready;
  logic w_ready;
  logic ar_ready;
  logic [31:0] status_word;
  otb_pkg::otb_cap_word_s cap_word;

  // Only word-aligned mapped offsets answer OKAY
  function automatic logic otb_addr_known(
    input logic [otb_pkg::OTB_ADDR_W-1:0] addr
  );
    case (addr)
      otb_pkg::OTB_CTRL_OFFSET,
      otb_pkg::OTB_STATUS_OFFSET,
      otb_pkg::OTB_A_STORE_OFFSET,
      otb_pkg::OTB_B_STORE_OFFSET,
      otb_pkg::OTB_COUNT_OFFSET: begin
        otb_addr_known = 1'h1;
      end
      default: begin
        otb_addr_known = 1'h0;
      end
    endcase
  endfunction

  // Qualified rising edge of one capture clock. Both late stages must agree,
  // so a pulse that lives only in the first stage is never counted.
  function automatic logic otb_rise_seen(
    input logic primed,
    input logic settled,
    input logic level_now,
    input logic level_was
  );
    otb_rise_seen = primed && settled && level_now && !level_was;
  endfunction

  // Bus source: the stored word when the select is high, else the live word
  function automatic otb_pkg::otb_data_t otb_pick(
    input logic use_stored,
    input otb_pkg::otb_data_t stored,
    input otb_pkg::otb_data_t live
  );
    otb_pick = use_stored ? stored : live;
  endfunction

  // Edge qualification: a clock change counts once stages 2 and 3 agree.
  // The first stage feeds only the second, so metastability stays there.
  assign a_settled = (cur.a_clk_sync[1] == cur.a_clk_sync[2]);
  assign b_settled = (cur.b_clk_sync[1] == cur.b_clk_sync[2]);

  // A level already high at reset release is taken for an edge once it reaches stage 3
  assign a_rise = otb_rise_seen(cur.primed, a_settled, cur.a_clk_sync[2],
    cur.a_clk_level);
  assign b_rise = otb_rise_seen(cur.primed, b_settled, cur.b_clk_sync[2],
    cur.b_clk_level);

  // Capture events leave through the two-entry buffer
  assign cap_push = a_rise || b_rise;
  assign cap_word.a_hit = a_rise;
  assign cap_word.b_hit = b_rise;
  assign cap_word.a_data = cur.a_sync[2];
  assign cap_word.b_data = cur.b_sync[2];

  // Bus handshakes: one write and one read in flight at most
  assign aw_ready = !cur.aw_held && !cur.bvalid;
  assign w_ready = !cur.w_held && !cur.bvalid;
  assign ar_ready = !cur.rvalid;

  // Status view of the block's own state
  always_comb begin
    status_word = '0;
    status_word[otb_pkg::OTB_ST_A_DRIVEN] = cur.a_drive;
    status_word[otb_pkg::OTB_ST_B_DRIVEN] = cur.b_drive;
    status_word[otb_pkg::OTB_ST_A_CLK] = cur.a_clk_level;
    status_word[otb_pkg::OTB_ST_B_CLK] = cur.b_clk_level;
    status_word[otb_pkg::OTB_ST_OVERFLOW] = cur.overflow;
    status_word[otb_pkg::OTB_ST_CAP_READY] = buf_ready;
  end

  // Next state of the whole block
  always_comb begin
    next_state = cur;

    // Three-stage synchronisers for clocks and bus data
    // Data take the same three stages as the clocks, so an edge meets its own data
    next_state.a_clk_sync = {cur.a_clk_sync[1:0], a_capture_clock_in};
    next_state.b_clk_sync = {cur.b_clk_sync[1:0], b_capture_clock_in};
    next_state.a_sync = {cur.a_sync[1:0], a_bus_in};
    next_state.b_sync = {cur.b_sync[1:0], b_bus_in};

    // Track the settled clock levels; the first settle only primes
    if (a_settled) begin
      next_state.a_clk_level = cur.a_clk_sync[2];
    end
    if (b_settled) begin
      next_state.b_clk_level = cur.b_clk_sync[2];
    end
    if (a_settled && b_settled) begin
      next_state.primed = 1'h1;
    end

    // Capture counters wrap silently
    if (a_rise) begin
      next_state.a_count = cur.a_count + otb_pkg::OTB_COUNT_W'(1);
    end
    if (b_rise) begin
      next_state.b_count = cur.b_count + otb_pkg::OTB_COUNT_W'(1);
    end

    // Drive state depends only on the controls, never on captures
    next_state.a_drive = !cur.ctrl.drive_enable_b
      && !cur.ctrl.drive_side_select;
    next_state.b_drive = !cur.ctrl.drive_enable_b
      && cur.ctrl.drive_side_select;

    // Source for the A bus: live B or the stored B word
    next_state.a_drive_data = otb_pick(cur.ctrl.b_to_a_source_select, b_store,
      cur.b_sync[2]);

    // Source for the B bus: live A or the stored A word
    next_state.b_drive_data = otb_pick(cur.ctrl.a_to_b_source_select, a_store,
      cur.a_sync[2]);

    // Write response retires first; channels are closed meanwhile
    if (cur.bvalid && axi_req_in.bready) begin
      next_state.bvalid = 1'h0;
    end

    // Address and data are taken in either order
    if (axi_req_in.awvalid && aw_ready) begin
      next_state.aw_held = 1'h1;
      next_state.aw_addr = axi_req_in.awaddr;
    end
    if (axi_req_in.wvalid && w_ready) begin
      next_state.w_held = 1'h1;
      next_state.w_data = axi_req_in.wdata;
      next_state.w_strb = axi_req_in.wstrb;
    end

    // Both halves present: apply the write and answer
    if (next_state.aw_held && next_state.w_held) begin
      next_state.aw_held = 1'h0;
      next_state.w_held = 1'h0;
      next_state.bvalid = 1'h1;
      if (otb_addr_known(next_state.aw_addr)) begin
        next_state.bresp = otb_pkg::OTB_RESP_OKAY;
      end else begin
        next_state.bresp = otb_pkg::OTB_RESP_SLVERR;
      end
      // Only byte lane 0 matters: every control and clear bit sits in it
      case (next_state.aw_addr)
        otb_pkg::OTB_CTRL_OFFSET: begin
          if (next_state.w_strb[0]) begin
            next_state.ctrl = otb_pkg::otb_ctrl_s'(next_state.w_data[3:0]);
          end
        end
        otb_pkg::OTB_STATUS_OFFSET: begin
          if (next_state.w_strb[0]
              && next_state.w_data[otb_pkg::OTB_ST_OVERFLOW]) begin
            next_state.overflow = 1'h0;
          end
        end
        default: begin
          next_state.overflow = next_state.overflow;
        end
      endcase
    end

    // Lost capture report; the set beats a clear in the same cycle
    if (cap_push && !buf_ready) begin
      next_state.overflow = 1'h1;
    end

    // Read channel
    if (cur.rvalid && axi_req_in.rready) begin
      next_state.rvalid = 1'h0;
    end
    if (axi_req_in.arvalid && ar_ready) begin
      next_state.rvalid = 1'h1;
      if (otb_addr_known(axi_req_in.araddr)) begin
        next_state.rresp = otb_pkg::OTB_RESP_OKAY;
      end else begin
        next_state.rresp = otb_pkg::OTB_RESP_SLVERR;
      end
      // Read data come from the state before this edge, not from a same-cycle write
      // A storage word read before its first capture returns unknown bits
      case (axi_req_in.araddr)
        otb_pkg::OTB_CTRL_OFFSET: begin
          next_state.rdata = 32'(cur.ctrl);
        end
        otb_pkg::OTB_STATUS_OFFSET: begin
          next_state.rdata = status_word;
        end
        otb_pkg::OTB_A_STORE_OFFSET: begin
          next_state.rdata = 32'(a_store);
        end
        otb_pkg::OTB_B_STORE_OFFSET: begin
          next_state.rdata = 32'(b_store);
        end
        otb_pkg::OTB_COUNT_OFFSET: begin
          next_state.rdata = '0;
          next_state.rdata[otb_pkg::OTB_CNT_A_LSB +: otb_pkg::OTB_COUNT_W] =
            cur.a_count;
          next_state.rdata[otb_pkg::OTB_CNT_B_LSB +: otb_pkg::OTB_COUNT_W] =
            cur.b_count;
        end
        default: begin
          next_state.rdata = '0;
        end
      endcase
    end
  end

  // Control state register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cur <= '0;
      cur.ctrl <= otb_pkg::OTB_CTRL_RESET;
    end else begin
      cur <= next_state;
    end
  end

  // Storage words: no reset, so they read unknown until first capture.
  // They load on every qualified edge even while their bus is driven.
  always_ff @(posedge clk_in) begin
    if (a_rise) begin
      a_store <= cur.a_sync[2];
    end
    if (b_rise) begin
      b_store <= cur.b_sync[2];
    end
  end

  // Capture event buffer; a full buffer never blocks storing
  otb_pair_buffer #(
    .WIDTH($bits(otb_pkg::otb_cap_word_s)),
    .DEPTH(otb_pkg::OTB_BUF_DEPTH)
  ) u_cap_buffer (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(cap_push),
    .in_ready_out(buf_ready),
    .in_data_in(cap_word),
    .out_valid_out(capture_valid_out),
    .out_ready_in(capture_ready_in),
    .out_data_out(capture_word_out)
  );

  assign capture_ready_out = buf_ready;

  // Pin drive, all from flip-flops
  // A control write reaches the pins one cycle after it lands
  assign a_bus_out = cur.a_drive_data;
  assign a_bus_oe_out = cur.a_drive;
  assign b_bus_out = cur.b_drive_data;
  assign b_bus_oe_out = cur.b_drive;

  // Bus answer
  assign axi_rsp_out.awready = aw_ready;
  assign axi_rsp_out.wready = w_ready;
  assign axi_rsp_out.bvalid = cur.bvalid;
  assign axi_rsp_out.bresp = cur.bresp;
  assign axi_rsp_out.arready = ar_ready;
  assign axi_rsp_out.rvalid = cur.rvalid;
  assign axi_rsp_out.rdata = cur.rdata;
  assign axi_rsp_out.rresp = cur.rresp;

endmodule

//--- otb_monitor.sv
`timescale 1ns/1ps

module otb_monitor (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire otb_pkg::otb_axi_req_s axi_req_in,
  input wire otb_pkg::otb_axi_rsp_s axi_rsp_out,
  input wire logic a_capture_clock_in,
  input wire logic b_capture_clock_in,
  input wire logic a_bus_oe_out,
  input wire logic b_bus_oe_out,
  input wire logic capture_ready_out,
  input wire logic capture_valid_out,
  input wire logic capture_ready_in,
  input wire otb_pkg::otb_cap_word_s capture_word_out
);
  // Single domain, so clock and reset are named once
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  one_side_only_a: assert property (!(a_bus_oe_out && b_bus_oe_out))
    else $error("both buses driven");
  reset_release_a: assert property ($rose(rst_b_in) |-> (!a_bus_oe_out && !b_bus_oe_out) [*4])
    else $error("bus driven after reset");
  // Only a register write may move the drive, never a capture edge
  drive_after_write_a: assert property (($changed(a_bus_oe_out) || $changed(b_bus_oe_out))
    |-> ($past(axi_rsp_out.bvalid) || $past(axi_rsp_out.bvalid, 2))) else $error("drive moved without write");
  cap_hold_a: assert property (capture_valid_out && !capture_ready_in
    |=> capture_valid_out && $stable(capture_word_out)) else $error("stalled capture word lost");
  a_capture_seen_a: assert property ($rose(a_capture_clock_in) && capture_ready_out
    |-> ##[2:10] (capture_valid_out && capture_word_out.a_hit)) else $error("a capture missing");
  b_capture_seen_a: assert property ($rose(b_capture_clock_in) && capture_ready_out
    |-> ##[2:10] (capture_valid_out && capture_word_out.b_hit)) else $error("b capture missing");
  write_answer_a: assert property (axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid
    && axi_rsp_out.wready |=> axi_rsp_out.bvalid) else $error("write not answered");
  read_answer_a: assert property (axi_req_in.arvalid && axi_rsp_out.arready |=> axi_rsp_out.rvalid)
    else $error("read not answered");
  aw_blocked_a: assert property (axi_rsp_out.bvalid |-> !axi_rsp_out.awready && !axi_rsp_out.wready)
    else $error("write taken while answering");
endmodule

bind otb_top otb_monitor otb_monitor_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .axi_req_in(axi_req_in),
  .axi_rsp_out(axi_rsp_out), .a_capture_clock_in(a_capture_clock_in), .b_capture_clock_in(b_capture_clock_in),
  .a_bus_oe_out(a_bus_oe_out), .b_bus_oe_out(b_bus_oe_out), .capture_ready_out(capture_ready_out),
  .capture_valid_out(capture_valid_out), .capture_ready_in(capture_ready_in),
  .capture_word_out(capture_word_out));

//--- otb_far_side.sv
`timescale 1ns/1ps

module otb_far_side (
  input wire otb_pkg::otb_data_t a_own_in,
  input wire otb_pkg::otb_data_t b_own_in,
  input wire otb_pkg::otb_data_t a_drv_in,
  input wire logic a_oe_in,
  input wire otb_pkg::otb_data_t b_drv_in,
  input wire logic b_oe_in,
  output otb_pkg::otb_data_t a_wire_out,
  output otb_pkg::otb_data_t b_wire_out
);
  // Outside logic backs off a bus while the device drives it, so no fight
  assign a_wire_out = a_oe_in ? a_drv_in : a_own_in;
  assign b_wire_out = b_oe_in ? b_drv_in : b_own_in;
endmodule

//--- testbench.sv
`timescale 1ns/1ps

module testbench;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  otb_pkg::otb_axi_req_s axi_req = '0;
  otb_pkg::otb_axi_rsp_s axi_rsp;
  logic a_clk = 1'b0;
  logic b_clk = 1'b0;
  logic cap_ready = 1'b1;
  otb_pkg::otb_data_t a_own = 8'h00;
  otb_pkg::otb_data_t b_own = 8'h00;
  otb_pkg::otb_data_t a_wire, b_wire, a_drv, b_drv, sa, sb, av, bv;
  logic a_oe, b_oe, cap_valid, cap_rdy;
  otb_pkg::otb_cap_word_s cap_word, e_cap, g_cap;
  logic [33:0] q_rd[$];
  otb_pkg::otb_cap_word_s q_cap[$];
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  int cnt_a = 0;
  int cnt_b = 0;
  integer seed = 32'h37f3cb7a;
  logic [3:0] ctrl = 4'h1;

  always #2.5 clk_in = ~clk_in;

  otb_top otb_top_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .axi_req_in(axi_req), .axi_rsp_out(axi_rsp),
    .a_capture_clock_in(a_clk), .b_capture_clock_in(b_clk), .a_bus_in(a_wire), .a_bus_out(a_drv),
    .a_bus_oe_out(a_oe), .b_bus_in(b_wire), .b_bus_out(b_drv), .b_bus_oe_out(b_oe), .capture_ready_out(cap_rdy),
    .capture_valid_out(cap_valid), .capture_ready_in(cap_ready), .capture_word_out(cap_word));

  otb_far_side otb_far_side_i (.a_own_in(a_own), .b_own_in(b_own), .a_drv_in(a_drv), .a_oe_in(a_oe),
    .b_drv_in(b_drv), .b_oe_in(b_oe), .a_wire_out(a_wire), .b_wire_out(b_wire));

  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
    compares++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Ready lines are kept high throughout, so each half is only dropped once taken
  task automatic wr(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= addr;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= data;
    axi_req.wstrb <= 4'hF;
    do begin
      @(posedge clk_in);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!axi_rsp.bvalid);
    check("write response", resp, axi_rsp.bresp);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
    q_rd.push_back({resp, data});
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= addr;
    do begin
      @(posedge clk_in);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (!axi_rsp.rvalid);
  endtask

  task automatic set_live();
    av = 8'($random(seed));
    bv = 8'($random(seed));
    a_own <= av;
    b_own <= bv;
  endtask

  // Expected drive of each bus as {enable, value}
  function automatic logic [8:0] drive_a();
    return {!ctrl[0] && !ctrl[1], ctrl[3] ? sb : bv};
  endfunction

  function automatic logic [8:0] drive_b();
    return {!ctrl[0] && ctrl[1], ctrl[2] ? sa : av};
  endfunction

  task automatic check_bus();
    logic [8:0] ea, eb;
    ea = drive_a();
    eb = drive_b();
    check("a enable", ea[8], a_oe);
    check("b enable", eb[8], b_oe);
    if (ea[8]) check("a drive", ea[7:0], a_drv);
    if (eb[8]) check("b drive", eb[7:0], b_drv);
  endtask

  // Bus held steady well around the edge, since the pins pass three sync stages
  task automatic pulse(input logic pa, input logic pb, input logic kept);
    logic [8:0] ea, eb;
    otb_pkg::otb_data_t aw, bw;
    repeat (4) @(posedge clk_in);
    ea = drive_a();
    eb = drive_b();
    aw = ea[8] ? ea[7:0] : av;
    bw = eb[8] ? eb[7:0] : bv;
    if (kept && (pa || pb)) q_cap.push_back({pa, pb, pa ? aw : 8'h00, pb ? bw : 8'h00});
    cnt_a += pa;
    cnt_b += pb;
    a_clk <= pa;
    b_clk <= pb;
    repeat (5) @(posedge clk_in);
    a_clk <= 1'b0;
    b_clk <= 1'b0;
    repeat (6) @(posedge clk_in);
    if (pa) sa = aw;
    if (pb) sb = bw;
  endtask

  // Oldest note meets each result as it appears; data of a side not hit is ignored
  always @(posedge clk_in) begin
    if (rst_b_in && axi_rsp.rvalid && axi_req.rready) begin
      check("read", (q_rd.size() > 0) ? q_rd.pop_front() : '1, {axi_rsp.rresp, axi_rsp.rdata});
    end
    if (rst_b_in && cap_valid && cap_ready) begin
      g_cap = cap_word;
      e_cap = (q_cap.size() > 0) ? q_cap.pop_front() : '1;
      if (!e_cap.a_hit) g_cap.a_data = 8'h00;
      if (!e_cap.b_hit) g_cap.b_data = 8'h00;
      check("capture word", e_cap, g_cap);
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    axi_req.bready <= 1'b1;
    axi_req.rready <= 1'b1;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    rd(otb_pkg::OTB_CTRL_OFFSET, 32'h1, otb_pkg::OTB_RESP_OKAY);
    check_bus();
    set_live();
    pulse(1'b1, 1'b1, 1'b1);
    set_live();
    pulse(1'b1, 1'b0, 1'b1);
    rd(otb_pkg::OTB_A_STORE_OFFSET, {24'h0, sa}, otb_pkg::OTB_RESP_OKAY);
    rd(otb_pkg::OTB_B_STORE_OFFSET, {24'h0, sb}, otb_pkg::OTB_RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      ctrl = {m[1] & ~m[0], m[1] & m[0], m[0], 1'b0};
      set_live();
      wr(otb_pkg::OTB_CTRL_OFFSET, {28'h0, ctrl}, otb_pkg::OTB_RESP_OKAY);
      rd(otb_pkg::OTB_CTRL_OFFSET, {28'h0, ctrl}, otb_pkg::OTB_RESP_OKAY);
      repeat (8) @(posedge clk_in);
      check_bus();
      pulse(1'b1, 1'b1, 1'b1);
      check_bus();
      set_live();
      repeat (8) @(posedge clk_in);
      check_bus();
    end
    for (int i = 0; i < 6; i++) begin
      ctrl = 4'($random(seed));
      set_live();
      wr(otb_pkg::OTB_CTRL_OFFSET, {28'h0, ctrl}, otb_pkg::OTB_RESP_OKAY);
      repeat (8) @(posedge clk_in);
      check_bus();
      pulse(1'b1, ctrl[1], 1'b1);
    end
    // Receiver stalls: two words fit, the third is dropped but still stored
    ctrl = 4'h1;
    wr(otb_pkg::OTB_CTRL_OFFSET, 32'h1, otb_pkg::OTB_RESP_OKAY);
    cap_ready <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      set_live();
      pulse(1'b1, 1'b0, k < 2);
    end
    check("capture ready", 34'h0, cap_rdy);
    rd(otb_pkg::OTB_STATUS_OFFSET, 32'h10, otb_pkg::OTB_RESP_OKAY);
    cap_ready <= 1'b1;
    rd(otb_pkg::OTB_A_STORE_OFFSET, {24'h0, sa}, otb_pkg::OTB_RESP_OKAY);
    check("capture ready", 34'h1, cap_rdy);
    wr(otb_pkg::OTB_STATUS_OFFSET, 32'h10, otb_pkg::OTB_RESP_OKAY);
    rd(otb_pkg::OTB_STATUS_OFFSET, 32'h20, otb_pkg::OTB_RESP_OKAY);
    rd(otb_pkg::OTB_COUNT_OFFSET, {cnt_b[15:0], cnt_a[15:0]}, otb_pkg::OTB_RESP_OKAY);
    // An unmapped write of zero must not enable any drive
    wr(8'h40, 32'h0, otb_pkg::OTB_RESP_SLVERR);
    rd(8'h40, 32'h0, otb_pkg::OTB_RESP_SLVERR);
    check_bus();
    repeat (20) @(posedge clk_in);
    check("notes left", 34'h0, 34'(q_rd.size() + q_cap.size()));
    report_and_stop();
  end
endmodule
